// ==== hw/data_memory_banking_stack.sv ====
// Banked 512-byte data memory with indirect access and the return stack.
// Assumes one core clock; core drives one request per cycle, answers next cycle.
//
// Functional notes
// RL1: 512 bytes of data memory, special registers and general storage.
// RL2: Special registers at 00-1F, 80-9F, 100-11F, 180-18B; rest is storage.
// RL3: Indirect port has no storage; accesses go to pointer's target.
// RL4: Indirect address is pointer low eight bits plus indirect bank bit.
// RL5: Reading indirect port with pointer zero returns 00.
// RL6: Indirect write addressing the port itself does nothing.
// RL7: Eight-entry return stack outside data and program maps.
// RL8: Stack and its index are not reachable by any instruction.
// RL9: Reset sets stack index to empty, top position.
// RL10: Calls and taken interrupts push the program counter.
// RL11: Returns pop the newest entry into the program counter.
// RL12: With stack full, interrupts only flag; vectoring waits for a return.
// RL13: Call on full stack pushes and drops the oldest entry.
// RL14: Status holds two-bit direct bank select and indirect bank bit.
// RL15: Offsets 70-7F of every bank reach one shared 16-byte area.
// RL16: Port, PC low, status, pointer, latch and intcon mirror in all banks.
`timescale 1ns/1ps
`include "dmem_map.svh"
module data_memory_banking_stack #(
  parameter int PC_W = `PC_W
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire dmem_pkg::mem_req_t    mem_req,
  input  wire logic [6:0]            direct_off,
  input  wire logic                  direct_sel,
  input  wire dmem_pkg::stack_req_t  stack_req,
  input  wire logic                  irq_pending,
  input  wire logic [7:0]            status_flags_in,
  input  wire logic                  status_flags_we,
  output logic [7:0]                 rdata,
  output logic                       rdata_valid,
  output logic [PC_W-1:0]            return_pc,
  output logic                       irq_accept,
  output logic                       stack_full,
  output logic [7:0]                 core_status,
  output logic [7:0]                 program_counter_high_latch,
  output logic [7:0]                 program_counter_low,
  output logic [7:0]                 int_control
);
  logic [7:0] ram [512];
  logic [7:0] core_status_reg;
  logic [7:0] indirect_pointer_reg;
  logic [7:0] pc_low_reg;
  logic [7:0] pc_high_latch_reg;
  logic [7:0] int_control_reg;
  logic [`DMEM_ADDR_W-1:0] eff_addr;
  logic [`DMEM_ADDR_W-1:0] phys_addr;
  logic       via_port;
  logic       null_access;
  dmem_pkg::target_t tgt;
  logic [PC_W-1:0] top_pc;
  logic            full;
  logic            empty;
  logic            push;

  // Classify an address within its bank
  function automatic dmem_pkg::target_t classify(input logic [`DMEM_ADDR_W-1:0] a);
    logic [6:0] o;
    o = a[6:0];
    if (o == `OFF_INDIRECT_PORT)
      classify = dmem_pkg::TGT_PORT; // RL16
    else if (o == `OFF_PC_LOW)
      classify = dmem_pkg::TGT_PC_LOW;
    else if (o == `OFF_CORE_STATUS)
      classify = dmem_pkg::TGT_STATUS;
    else if (o == `OFF_INDIRECT_PTR)
      classify = dmem_pkg::TGT_PTR;
    else if (o == `OFF_PC_HIGH_LATCH)
      classify = dmem_pkg::TGT_PROGRAM_COUNTER_HIGH_LATCH;
    else if (o == `OFF_INT_CONTROL)
      classify = dmem_pkg::TGT_INTCON;
    else if (a[8:7] == 2'b11 ? o <= `SFR_LAST_BANK3 : o <= `SFR_LAST_LOW)
      classify = dmem_pkg::TGT_OTHER_SFR; // RL2
    else
      classify = dmem_pkg::TGT_RAM;
  endfunction : classify

  // Offset access (direct_sel low) uses bank select, direct_sel high uses the full request address; port access uses pointer and indirect bank bit
  always_comb
  begin
    eff_addr = direct_sel ? mem_req.addr
                          : {core_status_reg[`BIT_BANK_HIGH], core_status_reg[`BIT_BANK_LOW],
                             direct_off}; // RL14
    via_port = (eff_addr[6:0] == `OFF_INDIRECT_PORT);
    if (via_port)
    begin
      eff_addr = {core_status_reg[`BIT_INDIRECT_BANK], indirect_pointer_reg}; // RL3 RL4
    end
    null_access = via_port && (eff_addr[6:0] == `OFF_INDIRECT_PORT); // RL5 RL6
    tgt = classify(eff_addr);
    phys_addr = (eff_addr[6:0] >= `SHARED_FIRST) ? {2'b00, eff_addr[6:0]} : eff_addr; // RL15
  end

  always_ff @(posedge mclk)
  begin
    if (mem_req.wr && !null_access && tgt == dmem_pkg::TGT_RAM)
    begin
      ram[phys_addr] <= mem_req.wdata; // RL1
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      core_status_reg <= `RST_CORE_STATUS;
    end
    else if (mem_req.wr && !null_access && tgt == dmem_pkg::TGT_STATUS)
    begin
      core_status_reg <= mem_req.wdata; // RL14
    end
    else if (status_flags_we)
    begin
      core_status_reg[4:0] <= status_flags_in[4:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      indirect_pointer_reg <= `RST_INDIRECT_PTR;
      pc_low_reg           <= `RST_PC_LOW;
      pc_high_latch_reg    <= `RST_PC_HIGH_LATCH;
      int_control_reg      <= `RST_INT_CONTROL;
    end
    else if (mem_req.wr && !null_access)
    begin
      case (tgt)
        dmem_pkg::TGT_PTR:    indirect_pointer_reg <= mem_req.wdata; // RL16
        dmem_pkg::TGT_PC_LOW: pc_low_reg           <= mem_req.wdata;
        dmem_pkg::TGT_PROGRAM_COUNTER_HIGH_LATCH: pc_high_latch_reg    <= mem_req.wdata;
        dmem_pkg::TGT_INTCON: int_control_reg      <= mem_req.wdata;
        default:              pc_low_reg           <= pc_low_reg;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rdata       <= 8'h00;
      rdata_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= mem_req.rd;
      if (!mem_req.rd || null_access)
      begin
        rdata <= 8'h00; // RL5
      end
      else
      begin
        case (tgt)
          dmem_pkg::TGT_PTR:       rdata <= indirect_pointer_reg;
          dmem_pkg::TGT_PC_LOW:    rdata <= pc_low_reg;
          dmem_pkg::TGT_STATUS:    rdata <= core_status_reg;
          dmem_pkg::TGT_PROGRAM_COUNTER_HIGH_LATCH:    rdata <= pc_high_latch_reg;
          dmem_pkg::TGT_INTCON:    rdata <= int_control_reg;
          dmem_pkg::TGT_RAM:       rdata <= ram[phys_addr];
          default:                 rdata <= 8'h00;
        endcase
      end
    end
  end

  // Interrupt vectoring is withheld while every stack entry is occupied
  assign push = stack_req.call || (stack_req.irq_take && !full); // RL10 RL12

  return_stack #(
    .DEPTH (`STACK_DEPTH),
    .PC_W  (PC_W)
  ) u_stack (
    .mclk    (mclk),
    .rst     (rst),
    .push    (push),
    .pop     (stack_req.ret),
    .push_pc (stack_req.pc),
    .top_pc  (top_pc),
    .full    (full),
    .empty   (empty)
  ); // RL7 RL8

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      return_pc  <= '0;
      irq_accept <= 1'b0;
      stack_full <= 1'b0;
    end
    else
    begin
      if (stack_req.ret && !empty)
      begin
        return_pc <= top_pc; // RL11
      end
      irq_accept <= irq_pending && !full; // RL12
      stack_full <= full;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      core_status                <= `RST_CORE_STATUS;
      program_counter_high_latch <= `RST_PC_HIGH_LATCH;
      program_counter_low        <= `RST_PC_LOW;
      int_control                <= `RST_INT_CONTROL;
    end
    else
    begin
      core_status                <= core_status_reg;
      program_counter_high_latch <= pc_high_latch_reg;
      program_counter_low        <= pc_low_reg;
      int_control                <= int_control_reg;
    end
  end
endmodule : data_memory_banking_stack

// ==== hw/dmem_map.svh ====
// Address map, field positions, reset values and sizes of the core data memory.
// Assumes inclusion by the package and the design modules of this block only.
`ifndef DMEM_MAP_SVH
`define DMEM_MAP_SVH
`define DMEM_ADDR_W          9
`define DMEM_BANK_SPAN       9'h080
`define OFF_INDIRECT_PORT    7'h00
`define OFF_PC_LOW           7'h02
`define OFF_CORE_STATUS      7'h03
`define OFF_INDIRECT_PTR     7'h04
`define OFF_PC_HIGH_LATCH    7'h0a
`define OFF_INT_CONTROL      7'h0b
`define SFR_LAST_LOW         7'h1f
`define SFR_LAST_BANK3       7'h0b
`define SHARED_FIRST         7'h70
`define BIT_INDIRECT_BANK    7
`define BIT_BANK_HIGH        6
`define BIT_BANK_LOW         5
`define RST_CORE_STATUS      8'h18
`define RST_PC_LOW           8'h00
`define RST_PC_HIGH_LATCH    8'h00
`define RST_INDIRECT_PTR     8'h00
`define RST_INT_CONTROL      8'h00
`define STACK_DEPTH          8
`define PC_W                 11
`endif

// ==== hw/dmem_pkg.sv ====
// Types shared by the data memory block.
// Assumes dmem_map.svh is on the include path.
`include "dmem_map.svh"
package dmem_pkg;
  typedef struct packed {
    logic                       rd;
    logic                       wr;
    logic [`DMEM_ADDR_W-1:0]    addr;
    logic [7:0]                 wdata;
  } mem_req_t;
  typedef struct packed {
    logic                       call;
    logic                       irq_take;
    logic                       ret;
    logic [`PC_W-1:0]           pc;
  } stack_req_t;
  typedef enum logic [2:0] {
    TGT_PORT, TGT_PC_LOW, TGT_STATUS, TGT_PTR, TGT_PROGRAM_COUNTER_HIGH_LATCH, TGT_INTCON, TGT_OTHER_SFR,
    TGT_RAM
  } target_t;
endpackage : dmem_pkg

// ==== hw/return_stack.sv ====
// Eight-entry circular return-address stack, invisible to the data map.
// Assumes push and pop come from the core's call, interrupt and return logic.
`timescale 1ns/1ps
module return_stack #(
  parameter int DEPTH = `STACK_DEPTH,
  parameter int PC_W  = `PC_W
) (
  input  wire logic            mclk,
  input  wire logic            rst,
  input  wire logic            push,
  input  wire logic            pop,
  input  wire logic [PC_W-1:0] push_pc,
  output logic      [PC_W-1:0] top_pc,
  output logic                 full,
  output logic                 empty
);
  localparam int IW = $clog2(DEPTH);
  logic [PC_W-1:0] entry [DEPTH];
  logic [IW-1:0]   stack_index_reg;
  logic [IW:0]     level_reg;
  logic [IW-1:0]   below;

  assign below  = stack_index_reg - IW'(1);
  assign top_pc = entry[below];
  assign full   = (level_reg == (IW+1)'(DEPTH));
  assign empty  = (level_reg == '0);

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      entry[stack_index_reg] <= push_pc; // RL10 RL13
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      stack_index_reg <= '0; // RL9
      level_reg       <= '0;
    end
    else if (push)
    begin
      stack_index_reg <= stack_index_reg + IW'(1); // RL13
      if (!full)
      begin
        level_reg <= level_reg + (IW+1)'(1);
      end
    end
    else if (pop && !empty)
    begin
      stack_index_reg <= below; // RL11
      level_reg       <= level_reg - (IW+1)'(1);
    end
  end
endmodule : return_stack

// ==== test/dmem_chk.sv ====
// Port assertions for the banked data memory and return stack.
// Assumes it is bound into data_memory_banking_stack with one clock.
`timescale 1ns/1ps
module dmem_chk #(
  parameter int PC_W = 11
) (
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire dmem_pkg::mem_req_t   mem_req,
  input wire logic                 direct_sel,
  input wire dmem_pkg::stack_req_t stack_req,
  input wire logic                 irq_pending,
  input wire logic [7:0]           rdata,
  input wire logic                 rdata_valid,
  input wire logic [PC_W-1:0]      return_pc,
  input wire logic                 irq_accept,
  input wire logic                 stack_full,
  input wire logic [7:0]           core_status,
  input wire logic [7:0]           program_counter_high_latch,
  input wire logic [7:0]           program_counter_low
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_read_answers: assert property (mem_req.rd |=> rdata_valid)
    else $error("read not answered");
  a_idle_quiet: assert property (!mem_req.rd |=> !rdata_valid && rdata == 8'h00)
    else $error("read data without read");
  a_reset_values: assert property (disable iff (1'b0) rst ##1 rst |=>
    core_status == 8'h18 && program_counter_low == 8'h00 && !stack_full)
    else $error("reset values wrong");
  a_irq_full_blocks: assert property (irq_accept |-> !stack_full)
    else $error("interrupt accepted on full stack");
  a_irq_room_takes: assert property ($past(irq_pending) && !stack_full |-> irq_accept)
    else $error("interrupt not accepted");
  a_latch_mirror: assert property (mem_req.wr && direct_sel && mem_req.addr[6:0] == 7'h0a
    |-> ##2 program_counter_high_latch[2:0] == $past(mem_req.wdata[2:0], 2))
    else $error("latch write lost");
  a_pcl_mirror: assert property (mem_req.wr && direct_sel && mem_req.addr[6:0] == 7'h02
    |-> ##2 program_counter_low == $past(mem_req.wdata, 2))
    else $error("pc low write lost");
  a_bank_bits: assert property (mem_req.wr && direct_sel && mem_req.addr[6:0] == 7'h03
    |-> ##2 core_status[7:5] == $past(mem_req.wdata[7:5], 2))
    else $error("bank bits not written");
  a_return_hold: assert property (!stack_req.ret |=> $stable(return_pc))
    else $error("return value moved without return");
  a_full_call_kept: assert property (stack_full && stack_req.call && !stack_req.ret
    && !$past(stack_req.ret) |-> ##2 stack_full)
    else $error("call on full stack lost fullness");
  a_full_drops: assert property (stack_full && stack_req.ret && !stack_req.call
    && !stack_req.irq_take && !$past(stack_req.ret) |-> ##2 !stack_full)
    else $error("return did not free a level");
endmodule : dmem_chk
bind data_memory_banking_stack dmem_chk #(.PC_W(PC_W)) dmem_chk_inst (
  .mclk(mclk), .rst(rst), .mem_req(mem_req), .direct_sel(direct_sel),
  .stack_req(stack_req), .irq_pending(irq_pending), .rdata(rdata),
  .rdata_valid(rdata_valid), .return_pc(return_pc), .irq_accept(irq_accept),
  .stack_full(stack_full), .core_status(core_status),
  .program_counter_high_latch(program_counter_high_latch),
  .program_counter_low(program_counter_low));

// ==== test/cpu_irq_model.sv ====
// Interrupt side of the core: keeps a pending flag and vectors once accepted.
// Assumes raise is a one-cycle bench request and acceptance arrives one cycle late.
`timescale 1ns/1ps
module cpu_irq_model (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic raise,
  input  wire logic irq_accept,
  output logic      irq_pending,
  output logic      irq_take
);
  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_pending <= 1'b0;
    else if (raise)
      irq_pending <= 1'b1;
    else if (irq_take)
      irq_pending <= 1'b0;
  end
  // One vector per request; the pulse pushes the program counter
  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_take <= 1'b0;
    else
      irq_take <= irq_accept && irq_pending && !irq_take;
  end
endmodule : cpu_irq_model

// ==== test/tb_data_memory_banking_stack.sv ====
// Bench for the banked data memory: map, indirect access and return stack.
// Assumes the checker is bound and the interrupt model stands at the core side.
`timescale 1ns/1ps
module tb_data_memory_banking_stack;
  logic                 mclk = 1'b0;
  logic                 rst = 1'b1;
  dmem_pkg::mem_req_t   req = '0;
  logic                 direct_sel = 1'b1;
  logic                 call_r = 1'b0;
  logic                 ret_r = 1'b0;
  logic                 raise = 1'b0;
  logic [10:0]          pc_r = 11'h000;
  wire logic            irq_take;
  wire logic            irq_pending;
  logic [7:0]           rdata;
  logic                 rdata_valid;
  logic [10:0]          return_pc;
  logic                 irq_accept;
  logic                 stack_full;
  logic [7:0]           core_status;
  logic [7:0]           pc_low_out;
  logic [7:0]           latch_out;
  logic [7:0]           intcon_out;
  logic [7:0]           flags_in = 8'h00;
  logic                 flags_we = 1'b0;
  int                   fails = 0;
  int                   num_checks = 0;
  int                   cycles = 0;
  int                   n;
  always #20 mclk = ~mclk;
  data_memory_banking_stack data_memory_banking_stack_inst (
    .mclk(mclk), .rst(rst), .mem_req(req), .direct_off(req.addr[6:0]),
    .direct_sel(direct_sel), .stack_req({call_r, irq_take, ret_r, pc_r}),
    .irq_pending(irq_pending), .status_flags_in(flags_in), .status_flags_we(flags_we),
    .rdata(rdata), .rdata_valid(rdata_valid), .return_pc(return_pc),
    .irq_accept(irq_accept), .stack_full(stack_full), .core_status(core_status),
    .program_counter_high_latch(latch_out), .program_counter_low(pc_low_out),
    .int_control(intcon_out));
  cpu_irq_model cpu_irq_model_inst (.mclk(mclk), .rst(rst), .raise(raise),
    .irq_accept(irq_accept), .irq_pending(irq_pending), .irq_take(irq_take));
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Read compares data and valid together; write just presents the byte
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d);
    req.rd = ~w;
    req.wr = w;
    req.addr = a;
    req.wdata = d;
    @(negedge mclk);
    if (!w) chk({2'b00, rdata_valid, rdata}, {3'b001, d});
  endtask : acc
  task automatic stk(input logic c, input logic r, input logic [10:0] v);
    call_r = c;
    ret_r = r;
    if (c) pc_r = v;
    @(negedge mclk);
    if (r) chk(return_pc, v);
  endtask : stk
  task automatic idle;
    req.rd = 1'b0;
    req.wr = 1'b0;
    call_r = 1'b0;
    ret_r = 1'b0;
    @(negedge mclk);
  endtask : idle
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      $display("wrong value at %0t: run took too long", $time);
      conclude();
    end
  end
  initial
  begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    chk(11'(core_status), 11'h018);
    acc(0, 9'h102, 8'h00);
    acc(1, 9'h170, 8'ha5);
    acc(0, 9'h070, 8'ha5);
    acc(1, 9'h0a0, 8'h3c);
    acc(1, 9'h020, 8'hc3);
    acc(0, 9'h0a0, 8'h3c);
    acc(1, 9'h101, 8'hff);
    acc(0, 9'h101, 8'h00);
    acc(1, 9'h18a, 8'h05);
    acc(0, 9'h00a, 8'h05);
    chk(11'(latch_out), 11'h005);
    acc(1, 9'h082, 8'h5d);
    acc(1, 9'h10b, 8'h81);
    chk(11'(pc_low_out), 11'h05d);
    acc(0, 9'h00b, 8'h81);
    chk(11'(intcon_out), 11'h081);
    acc(1, 9'h003, 8'h20);
    direct_sel = 1'b0;
    acc(0, 9'h020, 8'h3c);
    direct_sel = 1'b1;
    $display("map test done");
    acc(1, 9'h084, 8'h30);
    acc(1, 9'h003, 8'h80);
    acc(1, 9'h130, 8'h5a);
    acc(0, 9'h000, 8'h5a);
    acc(1, 9'h180, 8'h77);
    acc(0, 9'h130, 8'h77);
    acc(1, 9'h004, 8'h00);
    acc(1, 9'h000, 8'h66);
    acc(0, 9'h000, 8'h00);
    acc(0, 9'h004, 8'h00);
    flags_in = 8'h07;
    flags_we = 1'b1;
    idle();
    flags_we = 1'b0;
    acc(0, 9'h183, 8'h87);
    chk(11'(core_status), 11'h087);
    flags_in = 8'h00;
    flags_we = 1'b1;
    acc(1, 9'h003, 8'h41);
    flags_we = 1'b0;
    acc(0, 9'h103, 8'h41);
    idle();
    $display("indirect test done");
    for (n = 1; n <= 10; n++) stk(1, 0, 11'(n));
    chk(11'(stack_full), 11'h001);
    raise = 1'b1;
    idle();
    raise = 1'b0;
    pc_r = 11'h444;
    repeat (5)
    begin
      chk(11'(irq_accept), 11'h000);
      @(negedge mclk);
    end
    stk(0, 1, 11'h00a);
    idle();
    for (n = 0; n < 8 && irq_take !== 1'b1; n++) @(negedge mclk);
    chk(11'(irq_take), 11'h001);
    @(negedge mclk);
    stk(0, 1, 11'h444);
    for (n = 9; n >= 3; n--) stk(0, 1, 11'(n));
    stk(0, 1, 11'h003);
    idle();
    $display("stack test done");
    conclude();
  end
endmodule : tb_data_memory_banking_stack
